//--- hdl/edq_pkg.sv
// Constants, register map and code decoding for the edge delay qualifier
// Notes on behaviour
// RL1: Single-edge, select 0: rising edge delayed
// RL2: Single-edge: early drop abandons timing, restarts later
// RL3: Single-edge: undelayed edge passes straight through
// RL4: Single-edge, select 1: falling edge delayed
// RL5: Dual-edge: both edges delayed by full delay
// RL6: Dual-edge: input returning cancels pending change
// RL7: Dual-edge: no output interval below delay
// RL8: Dual-edge: select bit inverts the output
// RL9: Code adopted after 16*(difference+6) master periods
// RL10: Code accepted once stable, jumps straight there
// RL11: Code change mid-delay gives in-between delay
// RL12: During start-up output low, input ignored
// RL13: Start-up lasts 500 master periods
// RL14: Divider code settled before input acted on
// RL15: Start-up end copies input level to output
// RL16: Divider code alone sets select and ratio
// RL17: Integrator picks lowest suitable divide ratio; there is no integrator here, the ratio comes from the divider code alone
// RL18: Code top bit is the edge select
// RL19: Codes map to ratios 8^n, mirrored
// RL20: Delay equals ratio times master period
// RL21: Counter runs only while levels differ
package edq_pkg;

	// Timing: master period and core clock period in ns
	localparam int MASTER_PERIOD_NS = 1000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MASTER_CYCLES = MASTER_PERIOD_NS / CLK_PERIOD_NS;
	// Start-up length in master periods
	localparam int STARTUP_TICKS = 500;
	// Code change latency factors
	localparam int LAT_MULT = 16;
	localparam int LAT_OFFS = 6;
	// Divider code layout
	localparam int CODE_W = 4;
	localparam int CODE_SEL_BIT = 3;
	localparam logic [3:0] CODE_RST = 4'h0;
	// Register byte offsets
	localparam logic [7:0] OFS_CODE = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	// Status register field positions
	localparam int ST_SEL = 4;
	localparam int ST_STARTED = 5;
	localparam int ST_ACTIVE = 6;
	localparam int ST_OUT = 7;
	localparam int ST_IN = 8;
	localparam int ST_BUSY = 9;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Edge select is the top bit of the code
	function automatic logic edge_sel(input logic [3:0] code);
		return code[CODE_SEL_BIT]; // RL18
	endfunction : edge_sel

	// Ratio exponent: 3 bits per step, upper half mirrored
	function automatic logic [4:0] ratio_exp(input logic [3:0] code);
		logic [2:0] idx;
		idx = code[CODE_SEL_BIT] ? ~code[2:0] : code[2:0]; // RL19
		return 5'(idx) * 5'h3; // RL19
	endfunction : ratio_exp

endpackage : edq_pkg

//--- hdl/edq_code_filter.sv
// Divider code filter: outside the start-up load, accepts a new code only after it stays stable
`timescale 1ns/10ps
module edq_code_filter (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic tick_i,
	input wire logic load_i,
	input wire logic [3:0] raw_i,
	output logic [3:0] code_o,
	output logic busy_o
);

	logic [3:0] code_q; // Accepted code
	logic [3:0] cand_q; // Candidate code being watched
	logic [8:0] wait_q; // Master periods the candidate has held
	logic [3:0] diff_w; // Distance between candidate and accepted code
	logic [8:0] lat_w; // Required hold in master periods

	// Latency grows with the size of the jump
	assign diff_w = (cand_q > code_q) ? cand_q - code_q : code_q - cand_q;
	assign lat_w = 9'(edq_pkg::LAT_MULT) * (9'(diff_w) + 9'(edq_pkg::LAT_OFFS)); // RL9

	// Filter state; any wobble of the raw code restarts the hold count
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			code_q <= edq_pkg::CODE_RST;
			cand_q <= edq_pkg::CODE_RST;
			wait_q <= 9'h000;
		end else if (load_i) begin
			// Start-up end: take the settled code at once
			code_q <= raw_i; // RL14
			cand_q <= raw_i;
			wait_q <= 9'h000;
		end else if (raw_i != cand_q) begin
			// Wandering value: restart the hold
			cand_q <= raw_i; // RL10
			wait_q <= 9'h000;
		end else if (cand_q != code_q) begin
			if (tick_i) begin
				if (wait_q >= lat_w - 9'h001) begin
					// Jump straight to the new value, no stepping
					code_q <= cand_q; // RL10
					wait_q <= 9'h000;
				end else begin
					wait_q <= wait_q + 9'h001; // RL9
				end
			end
		end else begin
			wait_q <= 9'h000;
		end
	end

	assign code_o = code_q;
	assign busy_o = (cand_q != code_q);

	// Accepted code always equals the raw code seen on that edge
	a_code_jump: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RL10
		$changed(code_q) |-> code_q == $past(raw_i))
		else $error("accepted code is not the sampled code");

	// Outside a load, a change needs the full latency
	a_code_latency: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RL9
		$changed(code_q) && !$past(load_i) |-> $past(wait_q) == $past(lat_w) - 9'h001 && $past(tick_i))
		else $error("code adopted with wrong latency");

endmodule : edq_code_filter

//--- hdl/edq_top.sv
// Edge delay qualifier core with its AXI4-Lite register slave
`timescale 1ns/10ps
module edq_top #(
	parameter bit DUAL_EDGE = 1'b0, // 0: single-edge variant, 1: dual-edge
	parameter int MASTER_CYCLES = edq_pkg::MASTER_CYCLES, // Core cycles per master period
	parameter int ADDR_W = 8
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// Qualified signal path
	input wire logic sig_in_i,
	output logic sig_out_o,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic [2:0] s_axi_awprot_i,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	// AXI4-Lite write response
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	output logic [1:0] s_axi_bresp_o,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic [2:0] s_axi_arprot_i,
	// AXI4-Lite read data
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o
);

	// Register and bus state
	logic [3:0] code_reg_q; // Raw divider code written by software
	logic aw_hold_q; // Write address captured
	logic [ADDR_W-1:0] awaddr_q;
	logic w_hold_q; // Write data captured
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// Timing state
	logic [$clog2(MASTER_CYCLES+1)-1:0] pre_q; // Master period divider
	logic tick_q; // One-cycle master period enable
	logic [8:0] start_cnt_q; // Start-up master period count
	logic started_q; // Start-up finished
	logic [31:0] cnt_q; // Delay counter in core cycles
	logic out_q; // Output level

	// Combinational helpers
	logic [3:0] acc_code_w; // Code after filtering
	logic filt_busy_w;
	logic load_w; // Last start-up edge
	logic pol_w; // Edge select in use
	logic start_inv_w; // Inversion applied at start-up copy
	logic qin_w; // Input after polarity handling
	logic need_time_w; // Delayed transition pending
	logic pass_now_w; // Undelayed transition pending
	logic fire_w; // Delay elapsed this cycle
	logic [31:0] tgt_w; // Delay length in core cycles
	logic wr_go_w; // Both halves of a write present
	logic [31:0] status_w;

	// Master period divider: free running, one enable pulse per period
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pre_q <= '0;
			tick_q <= 1'b0;
		end else if (pre_q == ($bits(pre_q))'(MASTER_CYCLES - 1)) begin
			pre_q <= '0;
			tick_q <= 1'b1;
		end else begin
			pre_q <= pre_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	// Start-up: a fixed count of master periods, whatever the ratio
	assign load_w = !started_q && tick_q &&
		(start_cnt_q == 9'(edq_pkg::STARTUP_TICKS - 1)); // RL13
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			start_cnt_q <= 9'h000;
			started_q <= 1'b0;
		end else if (load_w) begin
			started_q <= 1'b1; // RL13
		end else if (!started_q && tick_q) begin
			start_cnt_q <= start_cnt_q + 9'h001; // RL13
		end
	end

	// Code filter; the code register is its only source
	edq_code_filter u_filter (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.tick_i(tick_q),
		.load_i(load_w),
		.raw_i(code_reg_q), // RL16
		.code_o(acc_code_w),
		.busy_o(filt_busy_w)
	);

	// Decode the accepted code into select bit and delay length
	assign pol_w = edq_pkg::edge_sel(acc_code_w); // RL16
	assign tgt_w = 32'(MASTER_CYCLES) << edq_pkg::ratio_exp(acc_code_w); // RL20
	assign start_inv_w = DUAL_EDGE && edq_pkg::edge_sel(code_reg_q); // RL15

	// Dual-edge inverts the input when selected; single-edge uses it raw
	assign qin_w = DUAL_EDGE ? (sig_in_i ^ pol_w) : sig_in_i; // RL8
	// Single-edge: the level equal to the select bit passes at once
	assign pass_now_w = started_q && !DUAL_EDGE && (qin_w != out_q) && (qin_w == pol_w); // RL3 RL4
	// Delayed transitions: any in dual-edge, the other edge in single-edge
	assign need_time_w = started_q && (qin_w != out_q) &&
		(DUAL_EDGE || (qin_w != pol_w)); // RL1 RL4 RL5
	// Compare with >= so a shorter ratio adopted mid-count still ends it
	assign fire_w = need_time_w && (cnt_q >= tgt_w - 32'h1); // RL11

	// Delay counter: counts only while levels differ, cleared on match
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_q <= 32'h0;
		end else if (!need_time_w || fire_w) begin
			cnt_q <= 32'h0; // RL21 RL2 RL6
		end else begin
			cnt_q <= cnt_q + 32'h1; // RL21
		end
	end

	// Output level: low and deaf to the input until start-up ends
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			out_q <= 1'b0;
		end else if (!started_q) begin
			// Copy the input without delay on the final start-up edge
			out_q <= load_w ? (sig_in_i ^ start_inv_w) : 1'b0; // RL12 RL15
		end else if (pass_now_w) begin
			out_q <= qin_w; // RL3
		end else if (fire_w) begin
			out_q <= qin_w; // RL1 RL5
		end
	end

	assign sig_out_o = out_q;

	// Status word shows the block's own state
	always_comb begin
		status_w = 32'h0;
		status_w[3:0] = acc_code_w;
		status_w[edq_pkg::ST_SEL] = pol_w;
		status_w[edq_pkg::ST_STARTED] = started_q;
		status_w[edq_pkg::ST_ACTIVE] = need_time_w;
		status_w[edq_pkg::ST_OUT] = out_q;
		status_w[edq_pkg::ST_IN] = sig_in_i;
		status_w[edq_pkg::ST_BUSY] = filt_busy_w;
	end

	// Write channels are taken in either order, one write at a time
	assign s_axi_awready_o = !aw_hold_q && !bvalid_q;
	assign s_axi_wready_o = !w_hold_q && !bvalid_q;
	assign wr_go_w = aw_hold_q && w_hold_q && !bvalid_q;

	// Capture write address and data as each arrives
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			aw_hold_q <= 1'b0;
			awaddr_q <= '0;
			w_hold_q <= 1'b0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else if (wr_go_w) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata_i;
				wstrb_q <= s_axi_wstrb_i;
			end
		end
	end

	// Register write and response; status and count are read only
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			code_reg_q <= edq_pkg::CODE_RST;
			bvalid_q <= 1'b0;
			bresp_q <= edq_pkg::RESP_OKAY;
		end else if (wr_go_w) begin
			bvalid_q <= 1'b1;
			if (awaddr_q[ADDR_W-1:2] == edq_pkg::OFS_CODE[ADDR_W-1:2]) begin
				// Low byte lane carries the code
				if (wstrb_q[0]) begin
					code_reg_q <= wdata_q[3:0];
				end
				bresp_q <= edq_pkg::RESP_OKAY;
			end else if (awaddr_q[ADDR_W-1:2] == edq_pkg::OFS_STATUS[ADDR_W-1:2] ||
				awaddr_q[ADDR_W-1:2] == edq_pkg::OFS_COUNT[ADDR_W-1:2]) begin
				// Writes to read-only words are dropped quietly
				bresp_q <= edq_pkg::RESP_OKAY;
			end else begin
				// Unmapped address
				bresp_q <= edq_pkg::RESP_SLVERR;
			end
		end else if (bvalid_q && s_axi_bready_i) begin
			bvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;
	assign s_axi_arready_o = !rvalid_q;

	// Read data is sampled on the address handshake
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= edq_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_i && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rresp_q <= edq_pkg::RESP_OKAY;
			case (s_axi_araddr_i[ADDR_W-1:2])
				edq_pkg::OFS_CODE[ADDR_W-1:2]: begin
					rdata_q <= {28'h0, code_reg_q};
				end
				edq_pkg::OFS_STATUS[ADDR_W-1:2]: begin
					rdata_q <= status_w;
				end
				edq_pkg::OFS_COUNT[ADDR_W-1:2]: begin
					rdata_q <= cnt_q;
				end
				default: begin
					// Unmapped: zero data with an error
					rdata_q <= 32'h0;
					rresp_q <= edq_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready_i) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rdata_o = rdata_q;
	assign s_axi_rresp_o = rresp_q;

	// Output held low through start-up
	a_startup_low: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RL12
		!started_q |-> !sig_out_o)
		else $error("output not low during start-up");

	// Start-up ends exactly after the full count of master periods
	a_startup_len: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RL13
		$rose(started_q) |-> $past(start_cnt_q) == 9'(edq_pkg::STARTUP_TICKS - 1) && $past(tick_q))
		else $error("start-up length wrong");

	// Input level copied at the end of start-up
	a_start_copy: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RL15
		$rose(started_q) |-> sig_out_o == ($past(sig_in_i) ^ $past(start_inv_w)))
		else $error("start-up copy of input wrong");

	// Undelayed edge reaches the output on the next edge
	a_fast_pass: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RL3
		pass_now_w |=> sig_out_o == $past(qin_w))
		else $error("undelayed edge not passed");

	// Any delayed output change follows a full delay count
	a_delay_full: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RL7
		$past(started_q) && $changed(out_q) && !$past(pass_now_w)
		|-> $past(cnt_q) >= $past(tgt_w) - 32'h1)
		else $error("output changed before the delay elapsed");

	// While timing, the counter advances and the output stays put
	a_hold_count: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RL5
		need_time_w && !fire_w |=> cnt_q == $past(cnt_q) + 32'h1 && $stable(out_q))
		else $error("pending delay did not advance");

	// Matching levels clear the counter, so the next edge starts at zero
	a_cnt_clear: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RL21
		started_q && (qin_w == out_q) |=> cnt_q == 32'h0)
		else $error("counter not cleared on match");

	// A write response stands until taken
	a_bresp_hold: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped early");

endmodule : edq_top

//--- verif/edq_sig_src.sv
// Behavioural model of the digital source that drives the watched input
`timescale 1ns/10ps
module edq_sig_src (
	input wire logic core_clk_i,
	output logic sig_o
);
	// Push-pull source: the line always carries a real level, low after power-up
	initial sig_o = 1'h0;

	// Moves the level; called just after a rising edge
	task automatic drive(input logic lvl);
		sig_o <= lvl;
	endtask : drive

	// Holds a level for w cycles, returns to the opposite level and rests 3 cycles
	task automatic pulse(input logic lvl, input int w);
		sig_o <= lvl;
		repeat (w) @(posedge core_clk_i);
		sig_o <= ~lvl;
		repeat (3) @(posedge core_clk_i);
	endtask : pulse
endmodule : edq_sig_src

//--- verif/edq_top_tb_top.sv
// Self-checking bench: single-edge and dual-edge cores side by side, one bus master
`timescale 1ns/10ps
module edq_top_tb_top;
	localparam int MC = 2; // Short master period keeps start-up at 1000 cycles
	localparam int TD = MC * 8; // Delay for divider codes 1 and 14
	typedef struct {logic [33:0] val; logic [33:0] msk;} edq_note_t;
	logic core_clk_i = 1'h0;
	logic reset_n_i = 1'h0;
	logic sig_in, sig_out, dual_out;
	logic smp = 1'h0; // Asks the monitor to compare the two outputs
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	logic [2:0] prot = 3'h0; // Protection bits, random per transfer, ignored by the block
	logic [3:0] wstrb = 4'h1; // Byte enables, lane 0 always set so the code lands
	logic d_awready, d_wready, d_bvalid, d_arready, d_rvalid; // Dual core bus answers
	logic [1:0] d_bresp, d_rresp;
	logic [31:0] d_rdata;
	edq_note_t notes[$]; // Expected results, oldest first
	edq_note_t cur;
	logic [33:0] seen;
	int err_count = 0, checks = 0, cyc = 0;

	// Single-edge core owns the bus answers
	edq_top #(.DUAL_EDGE(1'h0), .MASTER_CYCLES(MC)) DUT (.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i), .sig_in_i(sig_in), .sig_out_o(sig_out),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
		.s_axi_awprot_i(prot), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_araddr_i(araddr), .s_axi_arprot_i(prot),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp));
	// Dual-edge core sees identical bus traffic, so its handshakes track the first
	edq_top #(.DUAL_EDGE(1'h1), .MASTER_CYCLES(MC)) DUT_DUAL (.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i), .sig_in_i(sig_in), .sig_out_o(dual_out),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(d_awready), .s_axi_awaddr_i(awaddr),
		.s_axi_awprot_i(prot), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(d_wready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(d_bvalid),
		.s_axi_bready_i(bready), .s_axi_bresp_o(d_bresp), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(d_arready), .s_axi_araddr_i(araddr), .s_axi_arprot_i(prot),
		.s_axi_rvalid_o(d_rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(d_rdata),
		.s_axi_rresp_o(d_rresp));
	edq_sig_src src (.core_clk_i(core_clk_i), .sig_o(sig_in));

	// 100 MHz clock
	initial forever #5 core_clk_i = ~core_clk_i;

	// Counts and reports one comparison
	task automatic compare(input logic [33:0] got, input logic [33:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask : compare

	// Verdict and end of run
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_of_test

	// Hang guard: the whole sequence needs about 2100 cycles
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 6000) begin
			err_count++;
			end_of_test();
		end
	end

	// Monitor: at the falling edge every result is settled, so no race with the design
	always @(negedge core_clk_i) begin
		if ((bvalid && bready) || (rvalid && rready) || smp) begin
			seen = (bvalid && bready) ? {bresp, 32'h0} : (rvalid && rready) ? {rresp, rdata} :
				{32'h0, dual_out, sig_out};
			if (notes.size() == 0) begin
				compare(seen, ~seen);
			end else begin
				cur = notes.pop_front();
				compare(seen & cur.msk, cur.val);
				if (!smp) begin
					// Dual core sees the same traffic, so it owes the same response
					compare(((bvalid && bready) ? {d_bresp, 32'h0} : {d_rresp, d_rdata}) & cur.msk,
						cur.val);
					// While a response stands, its own address side refuses, the other is open
					compare({26'h0, d_bvalid, d_rvalid, d_awready, d_wready, d_arready, awready,
						wready, arready}, (bvalid && bready) ? 34'h89 : 34'h76);
				end
			end
		end
	end

	// Waits n cycles, then has both outputs compared with s (single) and d (dual)
	task automatic look(input int n, input logic s, input logic d);
		repeat (n) @(posedge core_clk_i);
		notes.push_back('{val: {32'h0, d, s}, msk: 34'h3});
		smp <= 1'h1;
		@(posedge core_clk_i);
		smp <= 1'h0;
	endtask : look

	// Bus write; address and data offered together, each released once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ha, hw, hb;
		hb = 1'h0;
		notes.push_back('{val: {r, 32'h0}, msk: {2'h3, 32'h0}});
		awaddr <= a;
		prot <= 3'($urandom);
		wdata <= d;
		wstrb <= 4'($urandom) | 4'h1;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		// Only the bench's hang guard ends this wait
		while (!hb) begin
			@(negedge core_clk_i);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid && bready;
			@(posedge core_clk_i);
			if (ha) awvalid <= 1'h0;
			if (hw) wvalid <= 1'h0;
		end
		bready <= 1'h0;
		// One idle edge so the next call never re-drives bready in this time step
		@(posedge core_clk_i);
	endtask : axw

	// Bus read; v and m give the expected {resp, data} and the bits that matter
	task automatic axr(input logic [7:0] a, input logic [33:0] v, input logic [33:0] m);
		logic ha, hr;
		hr = 1'h0;
		notes.push_back('{val: v, msk: m});
		araddr <= a;
		prot <= 3'($urandom);
		arvalid <= 1'h1;
		rready <= 1'h1;
		// Only the bench's hang guard ends this wait
		while (!hr) begin
			@(negedge core_clk_i);
			ha = arvalid && arready;
			hr = rvalid && rready;
			@(posedge core_clk_i);
			if (ha) arvalid <= 1'h0;
		end
		rready <= 1'h0;
		// One idle edge so the next call never re-drives rready in this time step
		@(posedge core_clk_i);
	endtask : axr

	// Main sequence
	initial begin
		void'($urandom(32'h1fba));
		src.drive(1'h1);
		repeat (5) @(posedge core_clk_i);
		reset_n_i <= 1'h1;
		look(900, 1'h0, 1'h0);
		look(105, 1'h1, 1'h1);
		axr(edq_pkg::OFS_CODE, 34'h0, 34'h3ffffffff);
		axr(8'h0c, {edq_pkg::RESP_SLVERR, 32'h0}, 34'h3ffffffff);
		// Levels match on both cores, so the delay counter rests at zero
		axr(edq_pkg::OFS_COUNT, 34'h0, 34'h3ffffffff);
		axw(8'h0c, 32'h5, edq_pkg::RESP_SLVERR);
		src.drive(1'h0);
		look(4, 1'h0, 1'h0);
		// Ratio 8 keeps the delay short yet well above a few cycles
		axw(edq_pkg::OFS_CODE, 32'h1, edq_pkg::RESP_OKAY);
		axw(edq_pkg::OFS_STATUS, 32'hf, edq_pkg::RESP_OKAY);
		repeat (190) @(posedge core_clk_i);
		axr(edq_pkg::OFS_STATUS, 34'h0, 34'hf);
		repeat (40) @(posedge core_clk_i);
		axr(edq_pkg::OFS_STATUS, 34'h1, 34'hf);
		// Random pulses shorter than the delay must all be swallowed
		repeat (3) src.pulse(1'h1, $urandom_range(12, 1));
		look(TD + 4, 1'h0, 1'h0);
		src.drive(1'h1);
		look(TD - 2, 1'h0, 1'h0);
		look(3, 1'h1, 1'h1);
		src.pulse(1'h0, 8);
		look(0, 1'h0, 1'h1);
		look(TD, 1'h1, 1'h1);
		src.drive(1'h0);
		look(3, 1'h0, 1'h1);
		look(TD - 2, 1'h0, 1'h0);
		// Code 14: edge select set, ratio 8 again
		axw(edq_pkg::OFS_CODE, 32'he, edq_pkg::RESP_OKAY);
		look(640, 1'h0, 1'h1);
		src.drive(1'h1);
		look(3, 1'h1, 1'h1);
		look(TD, 1'h1, 1'h0);
		src.drive(1'h0);
		look(TD - 4, 1'h1, 1'h0);
		look(8, 1'h0, 1'h1);
		repeat (4) @(posedge core_clk_i);
		end_of_test();
	end
endmodule : edq_top_tb_top
